// ### rtl/watchdog_timer.sv
// Watchdog timer with selectable prescaler, reload and prewarning
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_timer_params.svh"
module watchdog_timer
  import watchdog_timer_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic watchdog_disable_command,
  input wire logic watchdog_enable_command,
  input wire logic service_command,
  input wire logic prescale_slow,
  input wire logic [`WDT_COUNT_W-1:0] watchdog_reload_value,
  output logic prewarning_irq,
  output logic reset_request,
  output logic enabled,
  output logic [`WDT_COUNT_W-1:0] count_value
);
  wdt_tick_if tick_bus();

  wdt_state_e state;
  wdt_state_e next_state;
  logic next_enabled;
  logic [`WDT_COUNT_W-1:0] next_count_value;
  logic [`WDT_WARN_W-1:0] warn_count;
  logic [`WDT_WARN_W-1:0] next_warn_count;
  logic next_prewarning_irq;
  logic next_reset_request;
  logic service_taken;
  logic count_advance;
  logic overflow_event;
  logic warn_done;

  wdt_prescaler wdt_prescaler_i (
    .clock(clock),
    .srst(srst),
    .tick_bus(tick_bus.prescaler)
  );

  // =====================================================
  // Decoding helpers

  // Counting and service are live only before the failure sequence
  function automatic logic is_running(input wdt_state_e st);
    is_running = (st == wdt_running);
  endfunction

  // Prewarning window between overflow and the reset request
  function automatic logic is_warning(input wdt_state_e st);
    is_warning = (st == wdt_warning);
  endfunction

  // Overflow is the tick that carries the counter past all ones
  function automatic logic wraps_now(
    input logic [`WDT_COUNT_W-1:0] value,
    input logic advance
  );
    wraps_now = advance && (value == `WDT_COUNT_MAX);
  endfunction

  // Last cycle of the prewarning window
  function automatic logic warn_expired(input logic [`WDT_WARN_W-1:0] value);
    warn_expired = (value == `WDT_WARN_CYCLES - 1'b1);
  endfunction

  // Counter step; wraps to zero past all ones
  function automatic logic [`WDT_COUNT_W-1:0] count_plus_one(
    input logic [`WDT_COUNT_W-1:0] value
  );
    count_plus_one = value + 1'b1;
  endfunction

  function automatic logic [`WDT_WARN_W-1:0] warn_plus_one(
    input logic [`WDT_WARN_W-1:0] value
  );
    warn_plus_one = value + 1'b1;
  endfunction

  // =====================================================
  // Prescaler control
  // A service after overflow is ignored, so a runaway program cannot keep
  // postponing the reset request
  always_comb begin
    service_taken = service_command && is_running(state);
    tick_bus.clear = service_taken;
    // A disabled watchdog keeps its partial prescaler interval
    tick_bus.run = enabled && is_running(state);
    tick_bus.slow = prescale_slow;
  end

  // =====================================================
  // Counter events
  always_comb begin
    // The prescaler never ticks in a service cycle
    count_advance = enabled && is_running(state) && tick_bus.tick;
    overflow_event = wraps_now(count_value, count_advance);
    warn_done = is_warning(state) && warn_expired(warn_count);
  end

  // =====================================================
  // Enable flag
  always_comb begin
    next_enabled = enabled;
    // Enable wins when both commands coincide
    if (watchdog_enable_command) begin
      next_enabled = 1'b1;
    end else if (watchdog_disable_command) begin
      next_enabled = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      enabled <= 1'b1;
    end else begin
      enabled <= next_enabled;
    end
  end

  // =====================================================
  // Watchdog counter
  always_comb begin
    next_count_value = count_value;
    // Service wins over a tick in the same cycle
    if (service_taken) begin
      next_count_value = watchdog_reload_value;
    end else if (count_advance) begin
      next_count_value = count_plus_one(count_value);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count_value <= `WDT_RELOAD_RESET;
    end else begin
      count_value <= next_count_value;
    end
  end

  // =====================================================
  // Failure sequence state
  always_comb begin
    next_state = state;
    case (state)
      wdt_running: begin
        if (overflow_event) begin
          next_state = wdt_warning;
        end
      end
      wdt_warning: begin
        // Software can no longer cancel the sequence here
        if (warn_done) begin
          next_state = wdt_reset_req;
        end
      end
      wdt_reset_req: begin
        // Left only through reset
        next_state = wdt_reset_req;
      end
      default: begin
        next_state = wdt_running;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= wdt_running;
    end else begin
      state <= next_state;
    end
  end

  // =====================================================
  // Prewarning window
  always_comb begin
    next_warn_count = warn_count;
    if (overflow_event) begin
      next_warn_count = '0;
    end else if (is_warning(state) && !warn_done) begin
      next_warn_count = warn_plus_one(warn_count);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      warn_count <= '0;
    end else begin
      warn_count <= next_warn_count;
    end
  end

  // =====================================================
  // Interrupt and reset request
  always_comb begin
    // One-cycle prewarning, then a request that holds until reset
    next_prewarning_irq = overflow_event;
    next_reset_request = reset_request;
    if (warn_done) begin
      next_reset_request = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prewarning_irq <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      prewarning_irq <= next_prewarning_irq;
      reset_request <= next_reset_request;
    end
  end
endmodule
`default_nettype wire

// ### rtl/watchdog_timer_params.svh
// Constants of the watchdog timer
`ifndef WATCHDOG_TIMER_PARAMS_SVH
`define WATCHDOG_TIMER_PARAMS_SVH

`define WDT_COUNT_W 16
`define WDT_PRESCALE_W 14
`define WDT_DIV_SLOW 14'h3fff
`define WDT_DIV_FAST 14'h00ff
`define WDT_COUNT_MAX 16'hffff
`define WDT_RELOAD_RESET 16'h0000
`define WDT_WARN_CYCLES 8'h10
`define WDT_WARN_W 8

`endif

// ### rtl/watchdog_timer_pkg.sv
// Types of the watchdog timer
`default_nettype none
package watchdog_timer_pkg;
  typedef enum logic [1:0] {
    wdt_running,
    wdt_warning,
    wdt_reset_req
  } wdt_state_e;
endpackage
`default_nettype wire

// ### rtl/wdt_prescaler.sv
// Selectable clock prescaler for the watchdog counter
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_timer_params.svh"
module wdt_prescaler
  import watchdog_timer_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  wdt_tick_if.prescaler tick_bus
);
  logic [`WDT_PRESCALE_W-1:0] count;
  logic [`WDT_PRESCALE_W-1:0] next_count;
  logic [`WDT_PRESCALE_W-1:0] limit;

  // =====================================================
  // Divider
  always_comb begin
    limit = tick_bus.slow ? `WDT_DIV_SLOW : `WDT_DIV_FAST;
    next_count = count;
    tick_bus.tick = 1'b0;
    if (tick_bus.clear) begin
      next_count = '0;
    end else if (tick_bus.run) begin
      if (count >= limit) begin
        next_count = '0;
        tick_bus.tick = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ### rtl/wdt_tick_if.sv
// Tick carrier between prescaler and watchdog core
`timescale 1ns/1ns
`default_nettype none
interface wdt_tick_if;
  logic clear;
  logic run;
  logic slow;
  logic tick;
  modport core(output clear, output run, output slow, input tick);
  modport prescaler(input clear, input run, input slow, output tick);
endinterface
`default_nettype wire

// ### verif/watchdog_timer_assertions.sv
// Port checker for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_assertions (
  input wire logic clock,
  input wire logic srst,
  input wire logic watchdog_disable_command,
  input wire logic watchdog_enable_command,
  input wire logic service_command,
  input wire logic prescale_slow,
  input wire logic [15:0] watchdog_reload_value,
  input wire logic prewarning_irq,
  input wire logic reset_request,
  input wire logic enabled,
  input wire logic [15:0] count_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Set once the failure sequence has begun; service is refused from then on
  logic failing;
  always_ff @(posedge clock) begin
    if (srst) begin
      failing <= 1'b0;
    end else if (prewarning_irq) begin
      failing <= 1'b1;
    end
  end
  // ====
  // Checks
  property p_up; $past(srst) |-> enabled && count_value == 16'h0000; endproperty
  a_up: assert property (p_up) else $error("bad state after reset");
  property p_on; watchdog_enable_command |=> enabled; endproperty
  a_on: assert property (p_on) else $error("enable ignored");
  property p_off; !enabled && !watchdog_enable_command && !service_command
    |=> $stable(count_value); endproperty
  a_off: assert property (p_off) else $error("count moved while off");
  property p_step; $changed(count_value) && !$past(service_command)
    |-> count_value == $past(count_value) + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("count skipped");
  property p_srv; service_command && !failing && !prewarning_irq
    |=> count_value == $past(watchdog_reload_value); endproperty
  a_srv: assert property (p_srv) else $error("reload missed");
  property p_wrap; prewarning_irq |-> count_value == 16'h0000; endproperty
  a_wrap: assert property (p_wrap) else $error("irq without wrap");
  property p_req; prewarning_irq |-> ##16 $rose(reset_request); endproperty
  a_req: assert property (p_req) else $error("reset request late");
  property p_ord; $rose(reset_request) |-> $past(prewarning_irq, 16); endproperty
  a_ord: assert property (p_ord) else $error("request without irq");
  property p_lock; failing || prewarning_irq |=> $stable(count_value); endproperty
  a_lock: assert property (p_lock) else $error("count moved in failure");
  c_irq: cover property (prewarning_irq);
  c_srv: cover property (service_command);
  c_off: cover property (!enabled);
  c_req: cover property (reset_request);
endmodule
bind watchdog_timer watchdog_timer_assertions watchdog_timer_assertions_i (
  .clock(clock), .srst(srst), .watchdog_disable_command(watchdog_disable_command),
  .watchdog_enable_command(watchdog_enable_command), .service_command(service_command),
  .prescale_slow(prescale_slow), .watchdog_reload_value(watchdog_reload_value),
  .prewarning_irq(prewarning_irq), .reset_request(reset_request), .enabled(enabled),
  .count_value(count_value));
`default_nettype wire

// ### verif/watchdog_timer_tb.sv
// Self-checking bench for the watchdog timer
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic dis = 1'b0;
  logic en = 1'b0;
  logic srv = 1'b0;
  logic slow = 1'b0;
  logic [15:0] rel = 16'h0000;
  logic irq, req, on;
  logic [15:0] cnt, held;
  int fail_count = 0;
  int n_checks = 0;
  watchdog_timer watchdog_timer_i (.clock(clock), .srst(srst),
    .watchdog_disable_command(dis), .watchdog_enable_command(en),
    .service_command(srv), .prescale_slow(slow), .watchdog_reload_value(rel),
    .prewarning_irq(irq), .reset_request(req), .enabled(on), .count_value(cnt));
  initial begin
    forever #10 clock = ~clock;
  end
  // ====
  // Helpers
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task chk(input string s, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d bad %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task service(input logic [15:0] v);
    rel = v;
    srv = 1'b1;
    step(1);
    srv = 1'b0;
    chk("reload", cnt, v);
  endtask
  task span(input logic [15:0] v, input int n);
    step(n - 1);
    chk("hold", cnt, v);
    step(1);
    chk("tick", cnt, v + 16'h0001);
  endtask
  // ====
  // Scenarios
  task t_run;
    chk("on", 16'(on), 16'h0001);
    span(16'h0000, 256);
    service(16'h1234);
    span(16'h1234, 256);
    slow = 1'b1;
    service(16'h00ff);
    span(16'h00ff, 16384);
    slow = 1'b0;
    $display("run done");
  endtask
  task t_off;
    dis = 1'b1;
    step(1);
    dis = 1'b0;
    held = cnt;
    chk("off", 16'(on), 16'h0000);
    step(300);
    chk("frozen", cnt, held);
    en = 1'b1;
    step(1);
    en = 1'b0;
    chk("back", 16'(on), 16'h0001);
    dis = 1'b1;
    en = 1'b1;
    step(1);
    dis = 1'b0;
    en = 1'b0;
    chk("tie", 16'(on), 16'h0001);
    $display("off done");
  endtask
  task t_ovf;
    service(16'hffff);
    step(255);
    chk("irq early", 16'(irq), 16'h0000);
    step(1);
    chk("irq", 16'(irq), 16'h0001);
    chk("wrap", cnt, 16'h0000);
    rel = 16'h1234;
    srv = 1'b1;
    dis = 1'b1;
    step(1);
    srv = 1'b0;
    dis = 1'b0;
    chk("refused", cnt, 16'h0000);
    step(14);
    chk("req early", 16'(req), 16'h0000);
    step(1);
    chk("req", 16'(req), 16'h0001);
    step(5);
    chk("req held", 16'(req), 16'h0001);
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    chk("req cleared", 16'(req), 16'h0000);
    chk("on again", 16'(on), 16'h0001);
    span(16'h0000, 256);
    $display("ovf done");
  endtask
  initial begin
    step(20);
    srst = 1'b0;
    t_run;
    t_off;
    t_ovf;
    tally_and_finish;
  end
  initial begin
    #1000000;
    fail_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
